// ==== hdl/pfcs_pkg.sv ====
// constants for the parallel flash command sequencer
// What this block does
// - full erase aborts and erases nothing while any lock bit is set
// - full erase is erase-all command then data write of zero
// - lock-set data mask activates lock bit n for each set bit n
// - unlock data mask clears each selected lock bit
// - page-write-with-lock commands set their region lock bit on completion
// - lock-status read returns lock bits as a mask
// - gp-bit set data mask activates the matching general-purpose bits
// - gp-bit reset pattern deactivates bits whose position holds one
// - gp-bit status read returns general-purpose bits as a mask
// - security set is its command then data write of zero
// - while secure the port is disabled and no command runs
// - security clears only after an erase-pin erase has finished
// - memory-write data handshakes store the word at the current address
// - address advances after each memory-write or page-write-with-lock data word; new address phases restart it
// - version query answers the interface version on a data handshake
// - a new command first completes a pending page-write-with-lock load, flushing the buffer
// - on read, drive bus first, then assert valid, release on enable high
package pfcs_pkg;

  // handshake mode field
  localparam logic [3:0] ADDRESS_PHASE_LOW    = 4'h0;
  localparam logic [3:0] ADDRESS_PHASE_SECOND = 4'h1;
  localparam logic [3:0] ADDRESS_PHASE_THIRD  = 4'h2;
  localparam logic [3:0] ADDRESS_PHASE_FOURTH = 4'h3;
  localparam logic [3:0] COMMAND_PHASE_MODE   = 4'h8;
  localparam logic [3:0] DATA_PHASE_MODE      = 4'hd;

  // command codes
  localparam logic [15:0] FULL_WIPE_CODE        = 16'h0020;
  localparam logic [15:0] LOCK_SET_CODE         = 16'h0030;
  localparam logic [15:0] UNLOCK_REGIONS_CODE   = 16'h0031;
  localparam logic [15:0] LOCK_STATUS_CODE      = 16'h0032;
  localparam logic [15:0] GP_BIT_SET_CODE       = 16'h0033;
  localparam logic [15:0] GP_BIT_RESET_CODE     = 16'h0034;
  localparam logic [15:0] GP_BIT_STATUS_CODE    = 16'h0035;
  localparam logic [15:0] SECURITY_SET_CODE     = 16'h0036;
  localparam logic [15:0] MEMORY_WRITE_CODE     = 16'h001f;
  localparam logic [15:0] VERSION_QUERY_CODE    = 16'h001e;
  localparam logic [15:0] PAGE_WRITE_LOCK_CODE  = 16'h0012;
  localparam logic [15:0] ERASE_WRITE_LOCK_CODE = 16'h0013;
  localparam logic [15:0] NO_COMMAND_CODE       = 16'h0000;

  // version value, arbitrary
  localparam logic [15:0] PORT_VERSION = 16'h0001;

  // lock region index taken from word address bits
  localparam int unsigned LOCK_REGION_LSB = 10;

  // erase pin hold time
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned ERASE_HOLD_MS  = 220;
  localparam int unsigned ERASE_HOLD_CYC = (ERASE_HOLD_MS * 1000000) / CLK_PERIOD_NS + 1;

  // apb map
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] LOCK_OFFSET   = 8'h08;
  localparam logic [7:0] GPBIT_OFFSET  = 8'h0c;

  // field positions
  localparam int unsigned CTRL_WIDE_BIT    = 0;
  localparam int unsigned STAT_SECURE_BIT  = 0;
  localparam int unsigned STAT_ABORT_BIT   = 1;
  localparam int unsigned STAT_BUSY_BIT    = 2;
  localparam int unsigned STAT_PENDING_BIT = 3;
  localparam logic        CTRL_WIDE_RESET  = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_HELD  = 4'b0010,
    ST_PREP  = 4'b0100,
    ST_DRIVE = 4'b1000
  } pfcs_state_type;

endpackage

// ==== hdl/pfcs_sequencer.sv ====
// parallel fast-programming command sequencer with apb status and control
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module pfcs_sequencer #(
  parameter int unsigned ERASE_HOLD_CYCLES = pfcs_pkg::ERASE_HOLD_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // programming handshake
  input  wire logic [3:0]  mode,
  input  wire logic [15:0] data_in,
  output logic [15:0]      data_out,
  output logic             data_oe,
  input  wire logic        command_strobe_n,
  input  wire logic        output_enable_n,
  output logic             handshake_ready,
  output logic             data_valid_n,
  // erase pins
  input  wire logic        erase_pin,
  input  wire logic        test_pin,
  // memory and flash side
  output logic             mem_wr_en,
  output logic [31:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic             mem_erase_first,
  output logic             flash_flush,
  output logic             flash_erase_req,
  input  wire logic        flash_erase_done
);

  pfcs_pkg::pfcs_state_type state_q;
  logic [15:0] cmd_q;
  logic [31:0] addr_q;
  logic [15:0] lock_q;
  logic [15:0] gp_q;
  logic        secure_q;
  logic        wide_q;
  logic        abort_q;
  logic        busy_q;
  logic        pin_erase_q;
  logic        pend_q;
  logic        pend_erase_write_lock_code_q;
  logic [3:0]  pend_region_q;
  logic [24:0] hold_cnt_q;
  logic        data_oe_q;
  logic [15:0] data_out_q;
  logic        mem_wr_q;
  logic [31:0] mem_addr_q;
  logic [15:0] mem_wdata_q;
  logic        mem_ef_q;
  logic        flush_q;
  logic        erase_req_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        accept;
  logic [15:0] word;
  logic        is_cmd;
  logic        is_data;
  logic        is_addr;
  logic        page_lock_cmd;
  logic        wipe_ok;
  logic        wipe_abort;
  logic        pin_trigger;
  logic        apb_setup;
  logic        apb_write;
  // narrow bus only carries the low byte
  function automatic logic [15:0] bus_word(input logic [15:0] d, input logic wide);
    return wide ? d : {8'h00, d[7:0]};
  endfunction
  function automatic logic [31:0] addr_merge(input logic [31:0] a, input logic [15:0] w,
                                             input logic [1:0] ph, input logic wide);
    logic [31:0] r;
    r = a;
    if (wide) begin
      if (ph == 2'd0) begin
        r[15:0] = w;
      end else if (ph == 2'd1) begin
        r[31:16] = w;
      end
    end else begin
      r[{ph, 3'b000} +: 8] = w[7:0];
    end
    return r;
  endfunction
  // erase in progress refuses handshakes as well, the flash is not usable then
  assign accept        = (state_q == pfcs_pkg::ST_IDLE) && !secure_q &&
                         !busy_q && !command_strobe_n;
  assign word          = bus_word(data_in, wide_q);
  assign is_cmd        = (mode == pfcs_pkg::COMMAND_PHASE_MODE);
  assign is_data       = (mode == pfcs_pkg::DATA_PHASE_MODE);
  assign is_addr       = (mode[3:2] == 2'b00);
  assign page_lock_cmd = (cmd_q == pfcs_pkg::PAGE_WRITE_LOCK_CODE) ||
                         (cmd_q == pfcs_pkg::ERASE_WRITE_LOCK_CODE);
  assign wipe_ok       = accept && is_data && (cmd_q == pfcs_pkg::FULL_WIPE_CODE) &&
                         (word == 16'h0000) && (lock_q == 16'h0000);
  assign wipe_abort    = accept && is_data && (cmd_q == pfcs_pkg::FULL_WIPE_CODE) &&
                         (word == 16'h0000) && (lock_q != 16'h0000);
  assign pin_trigger   = (hold_cnt_q == 25'(ERASE_HOLD_CYCLES)) && !busy_q;
  // handshake state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pfcs_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        pfcs_pkg::ST_IDLE: begin
          if (accept) begin
            state_q <= pfcs_pkg::ST_HELD;
          end
        end
        pfcs_pkg::ST_HELD: begin
          if (!output_enable_n) begin
            state_q <= pfcs_pkg::ST_PREP;
          end else if (command_strobe_n) begin
            state_q <= pfcs_pkg::ST_IDLE;
          end
        end
        pfcs_pkg::ST_PREP: begin
          state_q <= pfcs_pkg::ST_DRIVE;
        end
        pfcs_pkg::ST_DRIVE: begin
          if (output_enable_n) begin
            state_q <= pfcs_pkg::ST_HELD;
          end
        end
      endcase
    end
  end
  // read data and bus direction; bus turns before valid falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_oe_q  <= 1'b0;
      data_out_q <= 16'h0000;
    end else if (state_q == pfcs_pkg::ST_HELD && !output_enable_n) begin
      data_oe_q <= 1'b1;
      unique case (cmd_q)
        pfcs_pkg::LOCK_STATUS_CODE:   data_out_q <= bus_word(lock_q, wide_q);
        pfcs_pkg::GP_BIT_STATUS_CODE: data_out_q <= bus_word(gp_q, wide_q);
        pfcs_pkg::VERSION_QUERY_CODE: data_out_q <= bus_word(pfcs_pkg::PORT_VERSION, wide_q);
        default:                      data_out_q <= 16'h0000;
      endcase
    end else if (state_q == pfcs_pkg::ST_DRIVE && output_enable_n) begin
      data_oe_q <= 1'b0;
    end
  end
  // command register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= pfcs_pkg::NO_COMMAND_CODE;
    end else if (accept && is_cmd) begin
      cmd_q <= word;
    end
  end
  // address buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 32'h0000_0000;
    end else if (accept && is_addr) begin
      addr_q <= addr_merge(addr_q, word, mode[1:0], wide_q);
    end else if (accept && is_data &&
                 (cmd_q == pfcs_pkg::MEMORY_WRITE_CODE || page_lock_cmd)) begin
      addr_q <= addr_q + 32'h0000_0001;
    end
  end
  // memory write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= 32'h0000_0000;
      mem_wdata_q <= 16'h0000;
      mem_ef_q    <= 1'b0;
    end else begin
      mem_wr_q <= accept && is_data &&
                  (cmd_q == pfcs_pkg::MEMORY_WRITE_CODE || page_lock_cmd);
      if (accept && is_data) begin
        mem_addr_q  <= addr_q;
        mem_wdata_q <= word;
        mem_ef_q    <= (cmd_q == pfcs_pkg::ERASE_WRITE_LOCK_CODE);
      end
    end
  end
  // pending page load; completed when the next command arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q        <= 1'b0;
      pend_erase_write_lock_code_q   <= 1'b0;
      pend_region_q <= 4'h0;
      flush_q       <= 1'b0;
    end else begin
      flush_q <= accept && is_cmd && pend_q;
      if (accept && is_cmd) begin
        pend_q <= 1'b0;
      end else if (accept && is_data && page_lock_cmd) begin
        pend_q        <= 1'b1;
        pend_erase_write_lock_code_q   <= (cmd_q == pfcs_pkg::ERASE_WRITE_LOCK_CODE);
        pend_region_q <= addr_q[pfcs_pkg::LOCK_REGION_LSB +: 4];
      end
    end
  end
  // lock bits; reads the pending region before it is overwritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 16'h0000;
    end else if (accept && is_cmd && pend_q) begin
      lock_q[pend_region_q] <= 1'b1;
    end else if (accept && is_data && cmd_q == pfcs_pkg::LOCK_SET_CODE) begin
      lock_q <= lock_q | word;
    end else if (accept && is_data && cmd_q == pfcs_pkg::UNLOCK_REGIONS_CODE) begin
      lock_q <= lock_q & ~word;
    end
  end
  // general-purpose bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_q <= 16'h0000;
    end else if (accept && is_data && cmd_q == pfcs_pkg::GP_BIT_SET_CODE) begin
      gp_q <= gp_q | word;
    end else if (accept && is_data && cmd_q == pfcs_pkg::GP_BIT_RESET_CODE) begin
      gp_q <= gp_q & ~word;
    end
  end
  // erase pin hold counter, only counts with the test pin low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= 25'h0000000;
    end else if (!erase_pin || test_pin) begin
      hold_cnt_q <= 25'h0000000;
    end else if (hold_cnt_q != 25'(ERASE_HOLD_CYCLES)) begin
      hold_cnt_q <= hold_cnt_q + 25'h0000001;
    end
  end
  // full erase request and busy tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_req_q <= 1'b0;
      busy_q      <= 1'b0;
      pin_erase_q <= 1'b0;
    end else begin
      erase_req_q <= wipe_ok || pin_trigger;
      if (wipe_ok || pin_trigger) begin
        busy_q      <= 1'b1;
        pin_erase_q <= pin_trigger;
      end else if (flash_erase_done) begin
        busy_q      <= 1'b0;
        pin_erase_q <= 1'b0;
      end
    end
  end
  // security bit; pin erase completion is its only way out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secure_q <= 1'b0;
    end else if (accept && is_data && cmd_q == pfcs_pkg::SECURITY_SET_CODE &&
                 word == 16'h0000) begin
      secure_q <= 1'b1;
    end else if (busy_q && pin_erase_q && flash_erase_done) begin
      secure_q <= 1'b0;
    end
  end
  // apb slave: zero wait states, read data captured in setup
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_q <= pfcs_pkg::CTRL_WIDE_RESET;
    end else if (apb_write && paddr == pfcs_pkg::CTRL_OFFSET) begin
      wide_q <= pwdata[pfcs_pkg::CTRL_WIDE_BIT];
    end
  end
  // abort flag: a new abort wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_q <= 1'b0;
    end else if (wipe_abort) begin
      abort_q <= 1'b1;
    end else if (apb_write && paddr == pfcs_pkg::STATUS_OFFSET &&
                 pwdata[pfcs_pkg::STAT_ABORT_BIT]) begin
      abort_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      unique case (paddr)
        pfcs_pkg::CTRL_OFFSET: prdata_q[pfcs_pkg::CTRL_WIDE_BIT] <= wide_q;
        pfcs_pkg::STATUS_OFFSET: begin
          prdata_q[pfcs_pkg::STAT_SECURE_BIT]  <= secure_q;
          prdata_q[pfcs_pkg::STAT_ABORT_BIT]   <= abort_q;
          prdata_q[pfcs_pkg::STAT_BUSY_BIT]    <= busy_q;
          prdata_q[pfcs_pkg::STAT_PENDING_BIT] <= pend_q;
        end
        pfcs_pkg::LOCK_OFFSET:  prdata_q[15:0] <= lock_q;
        pfcs_pkg::GPBIT_OFFSET: prdata_q[15:0] <= gp_q;
        default:                pslverr_q <= 1'b1;
      endcase
    end
  end
  // outputs
  assign prdata          = prdata_q;
  assign pready          = 1'b1;
  assign pslverr         = pslverr_q && psel && penable;
  assign data_out        = data_out_q;
  assign data_oe         = data_oe_q;
  assign handshake_ready = (state_q == pfcs_pkg::ST_IDLE);
  assign data_valid_n    = (state_q != pfcs_pkg::ST_DRIVE);
  assign mem_wr_en       = mem_wr_q;
  assign mem_addr        = mem_addr_q;
  assign mem_wdata       = mem_wdata_q;
  assign mem_erase_first = mem_ef_q;
  assign flash_flush     = flush_q;
  assign flash_erase_req = erase_req_q;
  // checks
  sequence read_open;
    state_q == pfcs_pkg::ST_HELD && !output_enable_n;
  endsequence
  sequence bus_then_valid;
    data_oe_q && data_valid_n ##1 data_oe_q && !data_valid_n;
  endsequence

  chk_wipe_abort: assert property (@(posedge pclk) disable iff (!presetn)
    wipe_abort |=> !erase_req_q && abort_q && !busy_q)
    else $error("erase issued while locked");
  chk_wipe_issue: assert property (@(posedge pclk) disable iff (!presetn)
    wipe_ok |=> erase_req_q ##1 !erase_req_q)
    else $error("full erase not issued once");
  chk_lock_set: assert property (@(posedge pclk) disable iff (!presetn)
    accept && is_data && cmd_q == pfcs_pkg::LOCK_SET_CODE |=> (lock_q & $past(word)) == $past(word))
    else $error("lock mask not applied");
  chk_unlock_clear: assert property (@(posedge pclk) disable iff (!presetn)
    accept && is_data && cmd_q == pfcs_pkg::UNLOCK_REGIONS_CODE |=> (lock_q & $past(word)) == 16'h0000)
    else $error("unlock mask not applied");
  chk_page_lock: assert property (@(posedge pclk) disable iff (!presetn)
    accept && is_cmd && pend_q |=> lock_q[$past(pend_region_q)] && flash_flush)
    else $error("page lock not set on completion");
  chk_gp_update: assert property (@(posedge pclk) disable iff (!presetn)
    accept && is_data && cmd_q == pfcs_pkg::GP_BIT_RESET_CODE |=> gp_q == ($past(gp_q) & ~$past(word)))
    else $error("gp reset pattern wrong");
  chk_secure_idle: assert property (@(posedge pclk) disable iff (!presetn)
    secure_q && state_q == pfcs_pkg::ST_IDLE |=> state_q == pfcs_pkg::ST_IDLE)
    else $error("handshake taken while secure");
  chk_secure_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(secure_q) |-> $past(pin_erase_q) && $past(flash_erase_done))
    else $error("security cleared without erase");
  chk_mem_write: assert property (@(posedge pclk) disable iff (!presetn)
    accept && is_data && cmd_q == pfcs_pkg::MEMORY_WRITE_CODE
    |=> mem_wr_en && mem_addr == $past(addr_q) && addr_q == $past(addr_q) + 32'h0000_0001)
    else $error("memory write or increment wrong");
  chk_read_order: assert property (@(posedge pclk) disable iff (!presetn)
    read_open |=> bus_then_valid)
    else $error("valid before bus driven");

endmodule

// ==== tb/pfcs_programmer.sv ====
// programmer model driving the write and read handshakes
`timescale 1ns/1ns
module pfcs_programmer (
  // clock
  input  wire logic        pclk,
  // device answers
  input  wire logic        handshake_ready,
  input  wire logic        data_valid_n,
  input  wire logic        data_oe,
  input  wire logic [15:0] data_out,
  // programmer drives
  output logic [3:0]       mode,
  output logic [15:0]      data_in,
  output logic             command_strobe_n,
  output logic             output_enable_n
);
  initial begin
    mode             = 4'h0;
    data_in          = 16'h0000;
    command_strobe_n = 1'b1;
    output_enable_n  = 1'b1;
  end

  // taken is low when the device never dropped ready
  task automatic write_hs(input logic [3:0] m, input logic [15:0] d, output logic taken);
    int n;
    taken = 1'b0;
    @(posedge pclk);
    mode             <= m;
    data_in          <= d;
    command_strobe_n <= 1'b0;
    for (n = 0; n < 20 && !taken; n++) begin
      @(negedge pclk);
      taken = (handshake_ready === 1'b0);
    end
    @(posedge pclk);
    command_strobe_n <= 1'b1;
    // released bus shows the inverse, not a stale copy
    data_in          <= ~d;
    for (n = 0; n < 20 && handshake_ready !== 1'b1; n++) @(negedge pclk);
  endtask

  task automatic read_hs(input logic [3:0] m, output logic [15:0] q);
    int n;
    @(posedge pclk);
    mode             <= m;
    command_strobe_n <= 1'b0;
    for (n = 0; n < 20 && handshake_ready !== 1'b0; n++) @(negedge pclk);
    @(posedge pclk);
    output_enable_n <= 1'b0;
    data_in         <= ~data_in;
    for (n = 0; n < 20 && data_valid_n !== 1'b0; n++) @(negedge pclk);
    q = (data_oe === 1'b1) ? data_out : ~data_out;
    @(posedge pclk);
    output_enable_n <= 1'b1;
    for (n = 0; n < 20 && data_valid_n !== 1'b1; n++) @(negedge pclk);
    @(posedge pclk);
    command_strobe_n <= 1'b1;
    for (n = 0; n < 20 && handshake_ready !== 1'b1; n++) @(negedge pclk);
  endtask
endmodule

// ==== tb/tb_parallel_flash_command_sequencer.sv ====
// self-checking bench for the command sequencer
`timescale 1ns/1ns
module tb_parallel_flash_command_sequencer;
  localparam int HOLD = 20;
  localparam logic [3:0] CM = pfcs_pkg::COMMAND_PHASE_MODE;
  localparam logic [3:0] DM = pfcs_pkg::DATA_PHASE_MODE;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] mask;
    logic [15:0] query;
    logic [15:0] want;
    logic [7:0]  off;
  } pfcs_tbrow_type;
  localparam pfcs_tbrow_type ROWS [4] = '{
    '{pfcs_pkg::LOCK_SET_CODE, 16'h00a5, pfcs_pkg::LOCK_STATUS_CODE, 16'h00a5, 8'h08},
    '{pfcs_pkg::UNLOCK_REGIONS_CODE, 16'h0005, pfcs_pkg::LOCK_STATUS_CODE, 16'h00a0, 8'h08},
    '{pfcs_pkg::GP_BIT_SET_CODE, 16'h0f0f, pfcs_pkg::GP_BIT_STATUS_CODE, 16'h0f0f, 8'h0c},
    '{pfcs_pkg::GP_BIT_RESET_CODE, 16'h0003, pfcs_pkg::GP_BIT_STATUS_CODE, 16'h0f0c, 8'h0c}};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  mode;
  logic [15:0] data_in;
  logic [15:0] data_out;
  logic        data_oe;
  logic        command_strobe_n;
  logic        output_enable_n;
  logic        handshake_ready;
  logic        data_valid_n;
  logic        erase_pin = 1'b0;
  logic        test_pin = 1'b1;
  logic        mem_wr_en;
  logic [31:0] mem_addr;
  logic [15:0] mem_wdata;
  logic        mem_erase_first;
  logic        flash_flush;
  logic        flash_erase_req;
  logic        flash_erase_done = 1'b0;
  logic [2:0]  done_sr = 3'h0;
  logic [31:0] wa[$];
  logic [15:0] wdq[$];
  int          n_erase = 0;
  int          n_flush = 0;
  int          err_total = 0;
  int          samples_checked = 0;

  always #5 pclk = ~pclk;

  pfcs_sequencer #(.ERASE_HOLD_CYCLES(HOLD)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .command_strobe_n(command_strobe_n),
    .output_enable_n(output_enable_n), .handshake_ready(handshake_ready),
    .data_valid_n(data_valid_n), .erase_pin(erase_pin), .test_pin(test_pin),
    .mem_wr_en(mem_wr_en), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_erase_first(mem_erase_first), .flash_flush(flash_flush),
    .flash_erase_req(flash_erase_req),
    .flash_erase_done(flash_erase_done));

  pfcs_programmer prog (.pclk(pclk), .handshake_ready(handshake_ready),
    .data_valid_n(data_valid_n), .data_oe(data_oe), .data_out(data_out), .mode(mode),
    .data_in(data_in), .command_strobe_n(command_strobe_n),
    .output_enable_n(output_enable_n));

  // flash answers an erase a few cycles after the request
  always @(posedge pclk) begin
    done_sr          <= {done_sr[1:0], flash_erase_req === 1'b1};
    flash_erase_done <= done_sr[2];
    if (mem_wr_en === 1'b1) begin
      wa.push_back(mem_addr);
      wdq.push_back(mem_wdata);
    end
    if (flash_erase_req === 1'b1) n_erase++;
    if (flash_flush === 1'b1) n_flush++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
    check(e, 1'b0);
  endtask

  task automatic hw(input logic [3:0] m, input logic [15:0] d);
    logic t;
    prog.write_hs(m, d, t);
  endtask

  task automatic cmd_read(input logic [15:0] c, input logic [15:0] exp);
    logic [15:0] q;
    hw(CM, c);
    prog.read_hs(DM, q);
    check(q, exp);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    conclude();
  end

  initial begin
    logic [31:0] q;
    logic e;
    logic t;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reg_is(8'h00, 32'h1);
    reg_is(8'h04, 32'h0);
    reg_is(8'h08, 32'h0);
    reg_is(8'h0c, 32'h0);
    apb(1'b1, 8'h10, 32'hffff, q, e);
    check(e, 1'b1);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      hw(CM, ROWS[i].cmd);
      hw(DM, ROWS[i].mask);
      cmd_read(ROWS[i].query, ROWS[i].want);
      reg_is(ROWS[i].off, {16'h0, ROWS[i].want});
    end
    // wipe refused while regions 5 and 7 stay locked
    hw(CM, pfcs_pkg::FULL_WIPE_CODE);
    hw(DM, 16'h0000);
    repeat (10) @(posedge pclk);
    check(n_erase, 0);
    reg_is(8'h04, 32'h2);
    apb(1'b1, 8'h04, 32'h2, q, e);
    reg_is(8'h04, 32'h0);
    hw(CM, pfcs_pkg::UNLOCK_REGIONS_CODE);
    hw(DM, 16'hffff);
    hw(CM, pfcs_pkg::FULL_WIPE_CODE);
    hw(DM, 16'h0000);
    repeat (10) @(posedge pclk);
    check(n_erase, 1);
    reg_is(8'h04, 32'h0);
    hw(CM, pfcs_pkg::MEMORY_WRITE_CODE);
    hw(pfcs_pkg::ADDRESS_PHASE_LOW, 16'h0010);
    hw(pfcs_pkg::ADDRESS_PHASE_SECOND, 16'h0002);
    hw(DM, 16'h1111);
    check(wa[$], 32'h00020010);
    hw(DM, 16'h2222);
    check(wa[$], 32'h00020011);
    check(wdq[$], 16'h2222);
    hw(pfcs_pkg::ADDRESS_PHASE_LOW, 16'h0040);
    hw(DM, 16'h3333);
    check(wa[$], 32'h00020040);
    // locking writes: regions 2 and 3, flushed by the next command
    hw(CM, pfcs_pkg::PAGE_WRITE_LOCK_CODE);
    hw(pfcs_pkg::ADDRESS_PHASE_LOW, 16'h0800);
    hw(pfcs_pkg::ADDRESS_PHASE_SECOND, 16'h0000);
    hw(DM, 16'h4444);
    check(wa[$], 32'h00000800);
    check(mem_erase_first, 1'b0);
    reg_is(8'h04, 32'h8);
    hw(CM, pfcs_pkg::ERASE_WRITE_LOCK_CODE);
    check(n_flush, 1);
    hw(pfcs_pkg::ADDRESS_PHASE_LOW, 16'h0c00);
    hw(DM, 16'h5555);
    check(wa[$], 32'h00000c00);
    check(mem_erase_first, 1'b1);
    cmd_read(pfcs_pkg::LOCK_STATUS_CODE, 16'h000c);
    check(n_flush, 2);
    cmd_read(pfcs_pkg::VERSION_QUERY_CODE, pfcs_pkg::PORT_VERSION);
    // narrow bus: four address phases, low byte first
    apb(1'b1, 8'h00, 32'h0, q, e);
    reg_is(8'h00, 32'h0);
    hw(CM, pfcs_pkg::MEMORY_WRITE_CODE);
    hw(pfcs_pkg::ADDRESS_PHASE_LOW, 16'h0034);
    hw(pfcs_pkg::ADDRESS_PHASE_SECOND, 16'h0012);
    hw(pfcs_pkg::ADDRESS_PHASE_THIRD, 16'h0005);
    hw(pfcs_pkg::ADDRESS_PHASE_FOURTH, 16'h0000);
    hw(DM, 16'h55aa);
    check(wa[$], 32'h00051234);
    check(wdq[$], 16'h00aa);
    apb(1'b1, 8'h00, 32'h1, q, e);
    hw(CM, pfcs_pkg::SECURITY_SET_CODE);
    hw(DM, 16'h0000);
    reg_is(8'h04, 32'h1);
    prog.write_hs(CM, pfcs_pkg::LOCK_SET_CODE, t);
    check(t, 1'b0);
    // operator sequence: test pin low, erase held; short hold must not count
    @(posedge pclk);
    test_pin  <= 1'b0;
    erase_pin <= 1'b1;
    repeat (HOLD / 2) @(posedge pclk);
    erase_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    reg_is(8'h04, 32'h1);
    erase_pin <= 1'b1;
    repeat (HOLD + 5) @(posedge pclk);
    erase_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    check(n_erase, 2);
    reg_is(8'h04, 32'h0);
    cmd_read(pfcs_pkg::VERSION_QUERY_CODE, pfcs_pkg::PORT_VERSION);
    hw(CM, pfcs_pkg::LOCK_SET_CODE);
    hw(DM, 16'h8001);
    // narrow bus first, so the reset value of the width bit really shows
    apb(1'b1, 8'h00, 32'h0, q, e);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reg_is(8'h08, 32'h0);
    reg_is(8'h00, 32'h1);
    conclude();
  end
endmodule
